// ==== dcid_core.sv ====
// Dual-channel half-band interpolation datapath with capture, strobe and registers
//
// Overview of operation
// - Select value zero runs two real paths
// - Channels A and B never mix in select value zero
// - Four half-band stages, each doubling rate
// - Switchable inverse sinc after the cascade
// - Factor field enables one to four stages
// - Bypass flag skips every interpolation stage
// - Capture on data clock rise outside external
// - External mode drives strobe from converter clock
// - Select value one gives single-sideband mixing
// - Select value two drives mixed result to B
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module dcid_core
    import dcid_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    input  wire logic        input_data_clock,
    input  wire logic        converter_clock_input,
    input  wire dcid_smp_t   sample_a_in,
    input  wire dcid_smp_t   sample_b_in,
    output logic             lock_strobe_output,
    output logic             sample_ready,
    output dcid_smp_t        dac_a_out,
    output dcid_smp_t        dac_b_out,
    output logic             dac_update
);

    typedef struct packed {
        dcid_cfg_t                              cfg;
        logic [3:0]                             cnt;
        logic                                   strobe;
        logic                                   dclk_q;
        logic                                   cclk_q;
        logic                                   ovf;
        logic                                   unf;
        logic                                   ready;
        dcid_smp_t [1:0]                        hold;
        dcid_smp_t [1:0][DCID_STAGES-1:0]       last;
        dcid_smp_t [1:0][DCID_STAGES-1:0]       sout;
        logic      [1:0][DCID_STAGES-1:0]       half;
        logic [1:0]                             mph;
        dcid_smp_t [1:0]                        tap1;
        dcid_smp_t [1:0]                        tap2;
        dcid_smp_t                              dac_a;
        dcid_smp_t                              dac_b;
        logic                                   upd;
        logic [31:0]                            rdata;
    } dcid_st_t;

    dcid_st_t            st_reg;
    dcid_st_t            st_next;
    dcid_pair_t          fifo_in;
    dcid_pair_t          fifo_out;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic [DCID_LVL_W-1:0] fifo_level;
    logic                capture;
    logic                pop_req;
    logic                tick;
    logic                data_rise;
    logic                ext_mode;
    logic [2:0]          nst;
    logic [3:0]          cnt_mask;
    logic [3:0]          cnt_nx;
    logic [DCID_STAGES-1:0] step;
    dcid_smp_t [1:0]     fin;
    dcid_smp_t           mix_a;
    dcid_smp_t           mix_b;
    dcid_smp_t [1:0]     isinc_y;

    // Clamp an 18-bit working value to the sample range
    function automatic dcid_smp_t sat16(input logic signed [17:0] v);
        if (v > DCID_SAT_MAX) begin
            return 16'h7FFF;
        end else if (v < DCID_SAT_MIN) begin
            return 16'h8000;
        end
        return v[15:0];
    endfunction

    // Midpoint of two samples, the odd-phase half-band output
    function automatic dcid_smp_t avg2(input dcid_smp_t x, input dcid_smp_t y);
        logic signed [16:0] s;
        s = 17'(x) + 17'(y);
        return 16'(s >>> 1);
    endfunction

    // Multiply by a carrier value of 0, +1 or -1
    function automatic logic signed [17:0] csel(input dcid_smp_t x, input logic [1:0] c);
        if (c == 2'h1) begin
            return 18'(x);
        end else if (c == 2'h2) begin
            return -18'(x);
        end
        return 18'sh00000;
    endfunction

    // Sample buffer between capture and the converter-rate drain
    dcid_fifo #(
        .W ($bits(dcid_pair_t)),
        .D (DCID_FIFO_DEP)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (capture),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_valid (fifo_out_valid),
        .out_ready (pop_req),
        .out_data  (fifo_out),
        .level     (fifo_level)
    );

    assign fifo_in.a = sample_a_in;
    assign fifo_in.b = sample_b_in;

    // Edge detection; pins are synchronous to clk so no synchroniser
    assign ext_mode  = (st_reg.cfg.ckm == DCID_CKM_EXT);
    assign tick      = converter_clock_input && !st_reg.cclk_q;
    assign data_rise = input_data_clock && !st_reg.dclk_q;

    // factor selects one to four stages
    assign nst      = st_reg.cfg.byp ? 3'h0 : 3'(st_reg.cfg.sel) + 3'h1;
    assign cnt_mask = 4'((5'h01 << nst) - 5'h01);
    assign cnt_nx   = (st_reg.cnt + 4'h1) & cnt_mask;

    // capture at the strobe's rising edge in external mode, else at the data clock rise
    assign capture = ext_mode ? (tick && cnt_nx == 4'h0) : data_rise;
    // Count bits above the mask are stale after a factor change; ignore them
    assign pop_req = tick && ((st_reg.cnt & cnt_mask) == 4'h0);

    // stage k steps every 2^(N-1-k) update ticks
    always_comb begin
        int sh;
        sh = 0;
        for (int k = 0; k < DCID_STAGES; k++) begin
            sh = int'(nst) - 1 - k;
            step[k] = tick && (k < int'(nst)) &&
                      ((st_reg.cnt & 4'((1 << sh) - 1)) == 4'h0);
        end
    end

    // per-channel result of the enabled cascade
    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            fin[ch] = (nst == 3'h0) ? st_reg.hold[ch] : st_reg.sout[ch][nst-3'h1];
        end
    end

    // Quarter-rate carrier: cos 1,0,-1,0 and sin 0,1,0,-1
    always_comb begin
        logic [1:0] c;
        logic [1:0] s;
        c = 2'h0;
        s = 2'h0;
        unique case (st_reg.mph)
            2'h0: c = 2'h1;
            2'h1: s = 2'h1;
            2'h2: c = 2'h2;
            2'h3: s = 2'h2;
        endcase
        mix_a = fin[0];
        mix_b = fin[1];
        if (st_reg.cfg.mode == DCID_MODE_SSB) begin
            mix_a = sat16(csel(fin[0], c) - csel(fin[1], s));
            mix_b = sat16(csel(fin[0], s) + csel(fin[1], c));
        // A held at zero, B carries the mix
        end else if (st_reg.cfg.mode == DCID_MODE_QUAD) begin
            mix_a = 16'h0000;
            mix_b = sat16(csel(fin[0], s) + csel(fin[1], c));
        end
        // select zero passes both paths unmixed
    end

    // three-tap high-frequency boost, one tap of delay
    always_comb begin
        logic signed [17:0] e;
        dcid_smp_t          x0;
        e  = 18'sh00000;
        x0 = 16'h0000;
        for (int ch = 0; ch < 2; ch++) begin
            x0 = (ch == 0) ? mix_a : mix_b;
            e  = (18'(st_reg.tap1[ch]) <<< 1) - 18'(x0) - 18'(st_reg.tap2[ch]);
            isinc_y[ch] = st_reg.cfg.isinc ?
                          sat16(18'(st_reg.tap1[ch]) + (e >>> DCID_ISNC_SHIFT)) : x0;
        end
    end

    // Next-state for strobe, datapath and registers
    always_comb begin
        st_next        = st_reg;
        st_next.dclk_q = input_data_clock;
        st_next.cclk_q = converter_clock_input;
        st_next.upd    = tick;
        st_next.ready  = fifo_in_ready;
        st_next.rdata  = 32'h0000_0000;
        if (tick) begin
            st_next.cnt = cnt_nx;
            st_next.mph = st_reg.mph + 2'h1;
        end
        // strobe rises on a converter clock rise in external mode; PLL mode holds it high, dual clock mode holds it low
        if (!ext_mode) begin
            st_next.strobe = (st_reg.cfg.ckm == DCID_CKM_PLL);
        end else if (nst == 3'h0) begin
            st_next.strobe = converter_clock_input;
        end else if (tick && cnt_nx == 4'h0) begin
            st_next.strobe = 1'b1;
        end else if (tick && cnt_nx == 4'((5'h01 << nst) >> 1)) begin
            st_next.strobe = 1'b0;
        end
        // Underrun keeps the last sample rather than inject a step
        if (pop_req && fifo_out_valid) begin
            st_next.hold[0] = fifo_out.a;
            st_next.hold[1] = fifo_out.b;
        end
        // half-band cascade, each stage doubles the rate
        for (int ch = 0; ch < 2; ch++) begin
            for (int k = 0; k < DCID_STAGES; k++) begin
                if (step[k]) begin
                    if (!st_reg.half[ch][k]) begin
                        st_next.sout[ch][k] = avg2((k == 0) ? st_reg.hold[ch] :
                                                   st_reg.sout[ch][k-1],
                                                   st_reg.last[ch][k]);
                        st_next.last[ch][k] = (k == 0) ? st_reg.hold[ch] :
                                              st_reg.sout[ch][k-1];
                        st_next.half[ch][k] = 1'b1;
                    end else begin
                        st_next.sout[ch][k] = st_reg.last[ch][k];
                        st_next.half[ch][k] = 1'b0;
                    end
                end
            end
        end
        // inverse sinc output at the update rate
        if (tick) begin
            st_next.tap2[0] = st_reg.tap1[0];
            st_next.tap2[1] = st_reg.tap1[1];
            st_next.tap1[0] = mix_a;
            st_next.tap1[1] = mix_b;
            st_next.dac_a   = isinc_y[0];
            st_next.dac_b   = isinc_y[1];
        end
        // Status clear by writing one; a new event wins over the clear
        if (reg_wr && reg_addr == DCID_OFF_STAT) begin
            if (reg_wdata[DCID_ST_OVF_BIT]) st_next.ovf = 1'b0;
            if (reg_wdata[DCID_ST_UNF_BIT]) st_next.unf = 1'b0;
        end
        if (capture && !fifo_in_ready) st_next.ovf = 1'b1;
        if (pop_req && !fifo_out_valid) st_next.unf = 1'b1;
        if (reg_wr && reg_addr == DCID_OFF_CFG) begin
            st_next.cfg = dcid_cfg_t'(reg_wdata[7:0]);
        end
        // Read data valid only in the cycle after the strobe
        if (reg_rd) begin
            if (reg_addr == DCID_OFF_CFG) begin
                st_next.rdata = {24'h000000, st_reg.cfg};
            end else if (reg_addr == DCID_OFF_STAT) begin
                st_next.rdata = {23'h000000, fifo_level, st_reg.unf, st_reg.ovf,
                                 st_reg.ready};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg     <= '0;
            st_reg.cfg <= dcid_cfg_t'(DCID_CFG_RST);
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata          = st_reg.rdata;
    assign lock_strobe_output = st_reg.strobe;
    assign sample_ready       = st_reg.ready;
    assign dac_a_out          = st_reg.dac_a;
    assign dac_b_out          = st_reg.dac_b;
    assign dac_update         = st_reg.upd;

    // Checks on the datapath and strobe
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_dual_unmixed: assert property (
        st_reg.cfg.mode == DCID_MODE_DUAL |-> (mix_a == fin[0] && mix_b == fin[1]))
        else $error("dual mode output was mixed");

    chk_chan_indep: assert property (
        tick && st_reg.cfg.mode == DCID_MODE_DUAL && !st_reg.cfg.isinc
        |=> dac_b_out == $past(fin[1]))
        else $error("channel B output not from its own path");

    chk_full_cascade: assert property (
        tick && nst == 3'h4 && st_reg.cnt == 4'h0 |-> step == 4'hF)
        else $error("not all four stages stepped at wrap");

    chk_isinc_off: assert property (
        tick && !st_reg.cfg.isinc |=> dac_a_out == $past(mix_a))
        else $error("inverse sinc not bypassed when off");

    chk_stage_count: assert property (
        tick && !st_reg.cfg.byp |-> (step >> st_reg.cfg.sel) == 4'h1)
        else $error("last enabled stage does not follow factor");

    chk_bypass_path: assert property (
        st_reg.cfg.byp |-> (step == 4'h0 && fin[0] == st_reg.hold[0]))
        else $error("bypass still runs a stage");

    chk_data_capture: assert property (
        !ext_mode |-> capture == (input_data_clock && !$past(input_data_clock)))
        else $error("capture not on data clock rise");

    chk_strobe_rise: assert property (
        ext_mode && tick && cnt_nx == 4'h0 && st_reg.cfg == $past(st_reg.cfg)
        |=> lock_strobe_output)
        else $error("strobe did not rise at wrap");

    chk_ssb_mix: assert property (
        st_reg.cfg.mode == DCID_MODE_SSB && st_reg.mph == 2'h0 |-> mix_b == fin[1])
        else $error("single-sideband mix wrong at phase zero");

    chk_quad_hold: assert property (
        st_reg.cfg.mode == DCID_MODE_QUAD |-> mix_a == 16'h0000)
        else $error("A output not held in quadrature mode");

    chk_bypass_rate: assert property (
        st_reg.cfg.byp && tick |-> pop_req)
        else $error("bypass update rate differs from input rate");

    cov_ssb_tick: cover property (st_reg.cfg.mode == DCID_MODE_SSB && tick);
    cov_quad_tick: cover property (st_reg.cfg.mode == DCID_MODE_QUAD && tick);
    cov_x16_pop: cover property (nst == 3'h4 && pop_req && fifo_out_valid);
    cov_fifo_full: cover property (capture && !fifo_in_ready);

endmodule // dcid_core

// ==== dcid_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module dcid_fifo #(
    parameter int W = 32,
    parameter int D = 32
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 in_valid,
    output logic                      in_ready,
    input  wire logic [W-1:0]         in_data,
    output logic                      out_valid,
    input  wire logic                 out_ready,
    output logic [W-1:0]              out_data,
    output logic [$clog2(D+1)-1:0]    level
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D+1);

    typedef struct packed {
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [CW-1:0] cnt;
    } dcid_fifo_st_t;

    dcid_fifo_st_t st_reg;
    dcid_fifo_st_t st_next;
    logic [W-1:0]  mem [D];
    logic          push;
    logic          pop;

    // Honest flags straight from the count
    assign in_ready  = (st_reg.cnt != CW'(D));
    assign out_valid = (st_reg.cnt != '0);
    assign out_data  = mem[st_reg.rptr];
    assign level     = st_reg.cnt;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and count update; pointers wrap at the depth
    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.wptr = (st_reg.wptr == AW'(D-1)) ? '0 : st_reg.wptr + 1'b1;
        end
        if (pop) begin
            st_next.rptr = (st_reg.rptr == AW'(D-1)) ? '0 : st_reg.rptr + 1'b1;
        end
        if (push && !pop) begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Storage carries no reset; only written on an accepted push
    always_ff @(posedge clk) begin
        if (push) begin
            mem[st_reg.wptr] <= in_data;
        end
    end

endmodule // dcid_fifo

// ==== dcid_host_model.sv ====
// Host-side model that drives clocks and parallel samples into the datapath
`timescale 1ns/100ps
module dcid_host_model
    import dcid_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ext,
    input  wire logic [2:0] nstg,
    input  wire logic       conv_en,
    input  wire logic       data_en,
    input  wire dcid_smp_t  a_val,
    input  wire dcid_smp_t  b_val,
    input  wire logic       lock_strobe_output,
    output logic            input_data_clock,
    output logic            converter_clock_input,
    output dcid_smp_t       sample_a_in,
    output dcid_smp_t       sample_b_in
);
    logic [7:0] cnt_reg;
    logic       dclk_reg;
    logic       strb_reg;

    // rates kept low
    // Update clock at clk/4, data clock at clk/(4*2^N); both stand low when stalled
    assign converter_clock_input = conv_en & cnt_reg[1];
    assign input_data_clock      = data_en & cnt_reg[nstg+1];

    // launch after capture
    // New sample is launched after the strobe rise in external mode, else at the data clock fall; held until the next one
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg     <= 8'h00;
            dclk_reg    <= 1'b0;
            strb_reg    <= 1'b0;
            sample_a_in <= 16'h0000;
            sample_b_in <= 16'h0000;
        end else begin
            cnt_reg  <= cnt_reg + 8'h01;
            dclk_reg <= input_data_clock;
            strb_reg <= lock_strobe_output;
            if (ext ? (lock_strobe_output & ~strb_reg) : (dclk_reg & ~input_data_clock)) begin
                sample_a_in <= a_val;
                sample_b_in <= b_val;
            end
        end
    end
endmodule // dcid_host_model

// ==== dcid_pkg.sv ====
// Shared constants and carrier types for the dual-channel interpolating datapath
package dcid_pkg;

    // Sample and structure sizes
    localparam int DCID_SMP_W    = 16;
    localparam int DCID_STAGES   = 4;
    localparam int DCID_FIFO_DEP = 32;
    localparam int DCID_LVL_W    = 6;

    // Register byte offsets on the plain register port
    localparam logic [7:0] DCID_OFF_CFG  = 8'h00;
    localparam logic [7:0] DCID_OFF_STAT = 8'h04;

    // Configuration field positions
    localparam int DCID_CFG_MODE_LSB = 0;
    localparam int DCID_CFG_SEL_LSB  = 2;
    localparam int DCID_CFG_BYP_BIT  = 4;
    localparam int DCID_CFG_ISNC_BIT = 5;
    localparam int DCID_CFG_CKM_LSB  = 6;

    // Status field positions
    localparam int DCID_ST_READY_BIT = 0;
    localparam int DCID_ST_OVF_BIT   = 1;
    localparam int DCID_ST_UNF_BIT   = 2;
    localparam int DCID_ST_LVL_LSB   = 3;

    // Datapath select and clock mode codes
    localparam logic [1:0] DCID_MODE_DUAL = 2'h0;
    localparam logic [1:0] DCID_MODE_SSB  = 2'h1;
    localparam logic [1:0] DCID_MODE_QUAD = 2'h2;
    localparam logic [1:0] DCID_CKM_EXT   = 2'h0;
    localparam logic [1:0] DCID_CKM_PLL   = 2'h1;
    localparam logic [1:0] DCID_CKM_DUAL  = 2'h2;

    // Reset value of the configuration register
    localparam logic [7:0] DCID_CFG_RST = 8'h00;

    // Saturation limits on the 18-bit working width
    localparam logic signed [17:0] DCID_SAT_MAX = 18'sh07FFF;
    localparam logic signed [17:0] DCID_SAT_MIN = 18'sh38000;

    // Inverse sinc correction shift
    localparam int DCID_ISNC_SHIFT = 4;

    typedef logic signed [DCID_SMP_W-1:0] dcid_smp_t;

    // Sample pair carried through the FIFO
    typedef struct packed {
        dcid_smp_t a;
        dcid_smp_t b;
    } dcid_pair_t;

    // Configuration register layout, msb first
    typedef struct packed {
        logic [1:0] ckm;
        logic       isinc;
        logic       byp;
        logic [1:0] sel;
        logic [1:0] mode;
    } dcid_cfg_t;

endpackage

// ==== dual_channel_interp_datapath_tb.sv ====
// Self-checking bench for the dual-channel interpolating datapath
`timescale 1ns/100ps
module dual_channel_interp_datapath_tb;
    import dcid_pkg::*;

    logic        clk;
    logic        rst;
    logic        reg_wr;
    logic        reg_rd;
    logic        ext;
    logic        conv_en;
    logic        data_en;
    logic [2:0]  nstg;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic        input_data_clock;
    logic        converter_clock_input;
    logic        lock_strobe_output;
    logic        sample_ready;
    logic        dac_update;
    dcid_smp_t   a_val;
    dcid_smp_t   b_val;
    dcid_smp_t   sample_a_in;
    dcid_smp_t   sample_b_in;
    dcid_smp_t   dac_a_out;
    dcid_smp_t   dac_b_out;
    int          error_cnt;
    int          samples_checked;

    dcid_core dcid_core_i (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .input_data_clock(input_data_clock), .converter_clock_input(converter_clock_input),
        .sample_a_in(sample_a_in), .sample_b_in(sample_b_in),
        .lock_strobe_output(lock_strobe_output), .sample_ready(sample_ready),
        .dac_a_out(dac_a_out), .dac_b_out(dac_b_out), .dac_update(dac_update)
    );

    dcid_host_model dcid_host_model_i (
        .clk(clk), .rst(rst), .ext(ext), .nstg(nstg), .conv_en(conv_en),
        .data_en(data_en), .a_val(a_val), .b_val(b_val),
        .lock_strobe_output(lock_strobe_output), .input_data_clock(input_data_clock),
        .converter_clock_input(converter_clock_input),
        .sample_a_in(sample_a_in), .sample_b_in(sample_b_in)
    );

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Register port cycles, entered and left at a rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdr(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
        @(posedge clk);
    endtask

    function automatic logic [31:0] cfgw(logic [1:0] ckm, logic isn, logic byp,
                                         logic [1:0] sel, logic [1:0] mode);
        return {24'h000000, ckm, isn, byp, sel, mode};
    endfunction

    // Stage count the datapath should use
    function automatic int nst(logic byp, logic [1:0] sel);
        return byp ? 0 : sel + 1;
    endfunction

    // Writes config with junk above bit 7, reads it back, steers the host model
    task automatic setcfg(input logic [1:0] ckm, input logic isn, input logic byp,
                          input logic [1:0] sel, input logic [1:0] mode);
        logic [31:0] d;
        wr(DCID_OFF_CFG, 32'hFFFFFF00 | cfgw(ckm, isn, byp, sel, mode));
        ext  <= (ckm == DCID_CKM_EXT);
        nstg <= 3'(nst(byp, sel));
        rdr(DCID_OFF_CFG, d);
        check("cfg readback", d, cfgw(ckm, isn, byp, sel, mode));
    endtask

    // Next converter update, bounded wait
    task automatic get_upd(output dcid_smp_t a, output dcid_smp_t b);
        int i;
        for (i = 0; i < 400; i++) begin
            @(negedge clk);
            if (dac_update === 1'b1) break;
        end
        if (i == 400) begin
            error_cnt++;
            test_done();
        end
        a = dac_a_out;
        b = dac_b_out;
        @(posedge clk);
    endtask

    // Strobe shape and update count over a 64-cycle window
    task automatic measure(input int er, input int eh);
        int   r = 0;
        int   h = 0;
        int   u = 0;
        logic p;
        @(negedge clk);
        p = lock_strobe_output;
        repeat (64) begin
            @(negedge clk);
            r += (lock_strobe_output === 1'b1 && p === 1'b0);
            h += (lock_strobe_output === 1'b1);
            u += (dac_update === 1'b1);
            p = lock_strobe_output;
        end
        check("strobe rises", r, er);
        check("strobe high", h, eh);
        check("update ticks", u, 16);
        @(posedge clk);
    endtask

    // Watchdog against a hung run
    initial begin
        #800000;
        error_cnt++;
        test_done();
    end

    initial begin
        logic [31:0] d;
        dcid_smp_t   x, y, a0, b0, a1, b1, a2, b2;
        int          n;
        logic        e;
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        ext = 1'b1;
        nstg = 3'h1;
        conv_en = 1'b1;
        data_en = 1'b1;
        a_val = 16'h0000;
        b_val = 16'h0000;
        error_cnt = 0;
        samples_checked = 0;
        d = $urandom(32'h547e6d94);
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset value, idle read data, unmapped place
        rdr(DCID_OFF_CFG, d);
        check("cfg reset", d, 32'(DCID_CFG_RST));
        @(negedge clk);
        check("rdata idle", reg_rdata, 32'h00000000);
        @(posedge clk);
        wr(8'h08, 32'h000000FF);
        rdr(8'h08, d);
        check("unmapped read", d, 32'h00000000);
        rdr(DCID_OFF_CFG, d);
        check("cfg after unmapped write", d, 32'(DCID_CFG_RST));
        // Every factor and bypass, every clock mode; constants must pass unchanged
        for (int k = 0; k < 5; k++) begin
            // isinc tried in dual mode only on flat input
            setcfg(2'(k % 3), k[0], k == 4, (k == 4) ? 2'h3 : 2'(k), DCID_MODE_DUAL);
            n = nst(k == 4, (k == 4) ? 2'h3 : 2'(k));
            e = (k % 3 == 0);
            x = 16'($urandom_range(16383) - 8192);
            y = 16'($urandom_range(16383) - 8192);
            a_val <= x;
            b_val <= y;
            repeat (1500) @(posedge clk);
            measure(e ? (16 >> n) : 0, e ? 32 : ((k % 3 == 1) ? 64 : 0));
            get_upd(a0, b0);
            check("dual a", a0, x);
            check("dual b", b0, y);
        end
        // Quarter-rate mixing rotates the pair each update
        setcfg(DCID_CKM_PLL, 1'b0, 1'b0, 2'h0, DCID_MODE_SSB);
        repeat (1500) @(posedge clk);
        get_upd(a0, b0);
        get_upd(a1, b1);
        check("ssb a", a1, dcid_smp_t'(-b0));
        check("ssb b", b1, a0);
        setcfg(DCID_CKM_DUAL, 1'b0, 1'b0, 2'h1, DCID_MODE_QUAD);
        repeat (1500) @(posedge clk);
        get_upd(a0, b0);
        get_upd(a1, b1);
        get_upd(a2, b2);
        check("quad a", a0, 16'h0000);
        check("quad b", b2, dcid_smp_t'(-b0));
        // Fill the buffer with the update clock stalled
        setcfg(DCID_CKM_PLL, 1'b0, 1'b1, 2'h0, DCID_MODE_DUAL);
        conv_en <= 1'b0;
        repeat (300) @(posedge clk);
        check("ready when full", 32'(sample_ready), 32'h0);
        rdr(DCID_OFF_STAT, d);
        check("ovf set", 32'(d[1:0]), 32'h2);
        check("level full", 32'(d[8:3]), 32'(DCID_FIFO_DEP));
        data_en <= 1'b0;
        // Clear both sticky flags so the drain must raise underrun afresh
        wr(DCID_OFF_STAT, 32'h00000006);
        rdr(DCID_OFF_STAT, d);
        check("ovf cleared", 32'(d[1]), 32'h0);
        check("unf cleared", 32'(d[2]), 32'h0);
        check("level kept", 32'(d[8:3]), 32'(DCID_FIFO_DEP));
        // Drain with the host stalled until underrun
        conv_en <= 1'b1;
        repeat (300) @(posedge clk);
        rdr(DCID_OFF_STAT, d);
        check("unf and ready", 32'({d[2], d[0]}), 32'h3);
        check("level empty", 32'(d[8:3]), 32'h00000000);
        data_en <= 1'b1;
        test_done();
    end
endmodule // dual_channel_interp_datapath_tb
